// >>> rid_divider.sv
/*
 * Counter that divides the sampled reference clock by a programmed
 * ratio, or passes it straight through when the divider is skipped.
 * Assumes ref_rise_in is a one-cycle pulse per reference rising edge
 * and ref_level_in the filtered reference level, both on clock_in.
 */
`timescale 1ns/10ps
module rid_divider #(
  parameter int RATIO_W = 20
) (
  input  wire logic               clock_in,
  input  wire logic               reset_n_in,
  input  wire logic               ce_in,
  input  wire logic               ref_rise_in,
  input  wire logic               ref_level_in,
  input  wire logic               set_n_in,
  input  wire logic               enable_n_in,
  input  wire logic               skip_in,
  input  wire logic [RATIO_W-1:0] ratio_in,
  output logic                    div_clk_out,
  output logic                    active_out
);

  typedef struct packed {
    logic [RATIO_W-1:0] count;
    logic               clk;
    logic               active;
  } rid_div_state_t;

  rid_div_state_t st_r;
  rid_div_state_t st_nxt;

  // Refused at elaboration: a one-bit counter cannot divide
  if (RATIO_W < 2)
  begin
    $error("rid_divider: RATIO_W must be at least 2");
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [RATIO_W-1:0] last;
    logic               ratio_ok;
    last     = ratio_in - RATIO_W'(1);
    ratio_ok = ratio_in >= RATIO_W'(rid_pkg::MIN_RATIO);
    st_nxt   = st_r;
    if (!set_n_in)
    begin
      // Held in set: counter cleared so release restarts cleanly
      st_nxt.count  = '0;
      st_nxt.clk    = 1'b0;
      st_nxt.active = 1'b0;
    end
    else if (enable_n_in)
    begin
      st_nxt.clk    = 1'b0;
      st_nxt.active = 1'b0;
    end
    else if (skip_in)
    begin
      st_nxt.count  = '0;
      st_nxt.clk    = ref_level_in;
      st_nxt.active = 1'b1;
    end
    else if (!ratio_ok)
    begin
      // Unsupported ratio: output parked low rather than glitching
      st_nxt.count  = '0;
      st_nxt.clk    = 1'b0;
      st_nxt.active = 1'b0;
    end
    else
    begin
      st_nxt.active = 1'b1;
      if (ref_rise_in)
      begin
        if (st_r.count >= last)
          st_nxt.count = '0;
        else
          st_nxt.count = st_r.count + RATIO_W'(1);
        // Rise only on wrap: no short first period after set
        st_nxt.clk = (st_nxt.count < (ratio_in >> 1)) &&
                     (st_r.clk || st_nxt.count == '0);
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_r <= '0;
    else if (ce_in)
      st_r <= st_nxt;
  end

  assign div_clk_out = st_r.clk;
  assign active_out  = st_r.active;

endmodule

// >>> rid_pkg.sv
/*
 * Constants and carrier types for the reference input divider: field
 * positions and reset value of the prescaler configuration register.
 * Assumes it is compiled before every module that names rid_pkg.
 */
package rid_pkg;

  // ****************************************************************
  // Configuration word layout
  // ****************************************************************
  localparam int          CFG_W        = 32;
  localparam int          RATIO_W      = 20;
  localparam int          RATIO_LSB    = 0;
  localparam int          SKIP_BIT     = 20;
  localparam int          ENB_BIT      = 21;
  localparam int          SETB_BIT     = 22;
  localparam int          PRIO_BIT     = 24;
  localparam int          MIN_RATIO    = 2;
  localparam logic [31:0] CFG_RESET    = 32'h0050_0000;
  localparam logic [31:0] CFG_WMASK    = 32'h017F_FFFF;

  // ****************************************************************
  // Input numbering and priority ranks
  // ****************************************************************
  localparam int          NUM_INPUTS   = 4;
  localparam int          IDX_W        = 2;
  localparam logic        RANK_FIRST   = 1'b0;
  localparam logic        RANK_SECOND  = 1'b1;
  localparam int          SYNC_STAGES  = 3;

  // Decoded fields of the configuration register
  typedef struct packed {
    logic                 rank;
    logic                 set_n;
    logic                 enable_n;
    logic                 divider_skip;
    logic [RATIO_W-1:0]   divide_count;
  } rid_cfg_t;

  // Selection key: lower value wins, rank first, then input index
  typedef struct packed {
    logic                 rank;
    logic [IDX_W-1:0]     index;
  } rid_key_t;

endpackage

// >>> rid_ref_model.sv
/* Reference clock source and feedback edge counter for the divider.
   Assumes run_in comes from the bench; 25 MHz keeps bypass legal. */
`timescale 1ns/10ps
module rid_ref_model #(
  parameter int HALF_NS = 20
) (
  input  wire logic   run_in,
  input  wire logic   div_clk_in,
  output logic        ref_clk_out,
  output logic [15:0] ref_rises_out,
  output logic [15:0] div_rises_out
);
  initial
  begin
    ref_clk_out = 1'b0;
    ref_rises_out = 16'h0;
    div_rises_out = 16'h0;
  end
  // Source stands still while stopped
  always #(HALF_NS) if (run_in) ref_clk_out = ~ref_clk_out;
  always @(posedge ref_clk_out) ref_rises_out <= ref_rises_out + 16'h1;
  always @(posedge div_clk_in) div_rises_out <= div_rises_out + 16'h1;
endmodule

// >>> rid_reference_input_divider.sv
/*
 * Reference input prescaler for one clock input: configuration
 * register, reference sampler, divider and switching-priority key.
 * Assumes ref_clk_in is asynchronous and at most a few tens of MHz so
 * that the 250 MHz sampler sees every level; software keeps the rules
 * on bypass and ratio frequencies.
 */
// Function
// - Bit 24 sets input switching rank
// - Equal ranks: lowest input index wins
// - Bit 22 low holds divider in set
// - Bit 21 low enables the divider
// - Bit 20 high passes reference undivided
// - Divide by 20-bit ratio, minimum two
`timescale 1ns/10ps
module rid_reference_input_divider #(
  parameter int INPUT_INDEX = 0,
  parameter int RATIO_W     = rid_pkg::RATIO_W
) (
  input  wire logic                    clock_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    ce_in,
  input  wire logic                    ref_clk_in,
  input  wire logic                    cfg_wr_en_in,
  input  wire logic [rid_pkg::CFG_W-1:0] cfg_wr_data_in,
  output logic [rid_pkg::CFG_W-1:0]    cfg_rd_data_out,
  output rid_pkg::rid_key_t            select_key_out,
  output logic                         div_clk_out,
  output logic                         div_active_out
);

  typedef struct packed {
    logic [rid_pkg::SYNC_STAGES-1:0] sync;
    logic                            ref_level;
    logic                            ref_rise;
    logic [rid_pkg::CFG_W-1:0]       cfg_word;
    rid_pkg::rid_key_t               key;
  } rid_state_t;

  rid_state_t        st_r;
  rid_state_t        st_nxt;
  rid_pkg::rid_cfg_t cfg;

  if (INPUT_INDEX < 0 || INPUT_INDEX >= rid_pkg::NUM_INPUTS)
  begin
    $error("rid: INPUT_INDEX out of range");
  end
  if (RATIO_W != rid_pkg::RATIO_W)
  begin
    $error("rid: ratio field is fixed by the register layout");
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  always_comb
  begin
    cfg.rank         = st_r.cfg_word[rid_pkg::PRIO_BIT];
    cfg.set_n        = st_r.cfg_word[rid_pkg::SETB_BIT];
    cfg.enable_n     = st_r.cfg_word[rid_pkg::ENB_BIT];
    cfg.divider_skip = st_r.cfg_word[rid_pkg::SKIP_BIT];
    cfg.divide_count =
      st_r.cfg_word[rid_pkg::RATIO_LSB +: rid_pkg::RATIO_W];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic settled;
    settled = st_r.sync[1] == st_r.sync[2];
    st_nxt  = st_r;
    // Stage 0 only feeds stage 1; the filter looks at stages 1 and 2
    st_nxt.sync = {st_r.sync[1:0], ref_clk_in};
    if (settled)
      st_nxt.ref_level = st_r.sync[2];
    st_nxt.ref_rise = settled && st_r.sync[2] && !st_r.ref_level;
    if (cfg_wr_en_in)
      st_nxt.cfg_word = cfg_wr_data_in & rid_pkg::CFG_WMASK;
    // Lower key wins: rank first, then lower input index
    st_nxt.key.rank  = cfg.rank;
    st_nxt.key.index = rid_pkg::IDX_W'(INPUT_INDEX);
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_r           <= '0;
      st_r.cfg_word  <= rid_pkg::CFG_RESET;
      st_r.key.index <= rid_pkg::IDX_W'(INPUT_INDEX);
    end
    else if (ce_in)
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Divider
  // ****************************************************************
  rid_divider #(
    .RATIO_W (rid_pkg::RATIO_W)
  ) u_divider (
    .clock_in     (clock_in),
    .reset_n_in   (reset_n_in),
    .ce_in        (ce_in),
    .ref_rise_in  (st_r.ref_rise),
    .ref_level_in (st_r.ref_level),
    .set_n_in     (cfg.set_n),
    .enable_n_in  (cfg.enable_n),
    .skip_in      (cfg.divider_skip),
    .ratio_in     (cfg.divide_count),
    .div_clk_out  (div_clk_out),
    .active_out   (div_active_out)
  );

  assign cfg_rd_data_out = st_r.cfg_word;
  assign select_key_out  = st_r.key;

endmodule

// >>> rid_reference_input_divider_assertions.sv
/* Port assertions for the reference input divider.
   Assumes a bind onto rid_reference_input_divider. */
`timescale 1ns/10ps
module rid_div_checker #(
  parameter int INPUT_INDEX = 0
) (
  input wire logic                       clock_in,
  input wire logic                       reset_n_in,
  input wire logic                       ce_in,
  input wire logic                       ref_clk_in,
  input wire logic                       cfg_wr_en_in,
  input wire logic [rid_pkg::CFG_W-1:0]  cfg_wr_data_in,
  input wire logic [rid_pkg::CFG_W-1:0]  cfg_rd_data_out,
  input wire rid_pkg::rid_key_t          select_key_out,
  input wire logic                       div_clk_out,
  input wire logic                       div_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic byp;
  assign byp = ce_in && cfg_rd_data_out[22:20] == 3'h5;
  wr_mask_a: assert property (
    ce_in && cfg_wr_en_in |=>
    cfg_rd_data_out == ($past(cfg_wr_data_in) & rid_pkg::CFG_WMASK))
    else $error("Config readback mismatch");
  cfg_hold_a: assert property (
    !(ce_in && cfg_wr_en_in) |=> $stable(cfg_rd_data_out))
    else $error("Config changed without write");
  rank_key_a: assert property (
    ce_in |=> select_key_out.rank == $past(cfg_rd_data_out[24]))
    else $error("Rank does not follow config");
  index_key_a: assert property (
    select_key_out.index == 2'(INPUT_INDEX))
    else $error("Key index wrong");
  set_hold_a: assert property (
    ce_in && !cfg_rd_data_out[22] |=> !div_clk_out && !div_active_out)
    else $error("Output while held in set");
  enable_off_a: assert property (
    ce_in && cfg_rd_data_out[21] |=> !div_clk_out)
    else $error("Output while disabled");
  low_ratio_a: assert property (
    ce_in && !cfg_rd_data_out[20] && cfg_rd_data_out[19:0] < 20'h2
    |=> !div_clk_out && !div_active_out)
    else $error("Output with ratio below two");
  // Pin to output takes five edges: three sync stages, filter, divider
  skip_high_a: assert property (
    (byp && ref_clk_in) [*5] |=> div_clk_out)
    else $error("Bypass output not high");
  skip_low_a: assert property (
    (byp && !ref_clk_in) [*5] |=> !div_clk_out)
    else $error("Bypass output not low");
  cover property (ce_in && cfg_wr_en_in);
  cover property (div_active_out && !cfg_rd_data_out[20]);
  cover property ((byp && !ref_clk_in) [*5]);
endmodule

// >>> rid_reference_input_divider_tb.sv
/* Self-checking bench: register writes, bypass, divide ratios, holds.
   Assumes rid_ref_model supplies the reference clock. */
`timescale 1ns/10ps
module rid_reference_input_divider_tb;
  logic              clock_in = 1'b0;
  logic              reset_n_in = 1'b0;
  logic              ce_in = 1'b1;
  logic              run = 1'b0;
  logic              wr_en = 1'b0;
  logic [31:0]       wr_data = 32'h0;
  logic [31:0]       rd_data;
  rid_pkg::rid_key_t key;
  logic              ref_clk;
  logic              div_clk;
  logic              active;
  logic [15:0]       n_ref;
  logic [15:0]       n_div;
  int                n_mismatch = 0;
  int                comparisons = 0;
  int                r0;
  int                d0;
  always #2 clock_in = ~clock_in;
  rid_reference_input_divider #(.INPUT_INDEX(2))
    rid_reference_input_divider_i (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .ce_in(ce_in), .ref_clk_in(ref_clk),
    .cfg_wr_en_in(wr_en), .cfg_wr_data_in(wr_data),
    .cfg_rd_data_out(rd_data), .select_key_out(key),
    .div_clk_out(div_clk), .div_active_out(active));
  rid_ref_model rid_ref_model_i (.run_in(run), .div_clk_in(div_clk),
    .ref_clk_out(ref_clk), .ref_rises_out(n_ref), .div_rises_out(n_div));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge clock_in);
    wr_en = 1'b1;
    wr_data = d;
    @(negedge clock_in);
    wr_en = 1'b0;
    @(negedge clock_in);
  endtask
  // Divisor 0 means no output edges at all
  task automatic run_ref(input int ns, input int div);
    r0 = n_ref;
    d0 = n_div;
    run = 1'b1;
    #(ns);
    run = 1'b0;
    #200;
    chk(n_div - d0, div == 0 ? 0 : (n_ref - r0) / div);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  initial
  begin
    repeat (5) @(negedge clock_in);
    reset_n_in = 1'b1;
    chk(rd_data, rid_pkg::CFG_RESET);
    chk(32'(key), 32'h2);
    run_ref(400, 1);
    wr(32'hFFFF_FFFF);
    chk(rd_data, rid_pkg::CFG_WMASK);
    chk(32'(key.rank), 32'h1);
    wr(32'h0000_0000);
    chk(32'(key.rank), 32'h0);
    run_ref(400, 0);
    chk(32'(active), 32'h0);
    for (int r = 2; r < 6; r += 1 + (r == 3))
    begin
      wr(32'(r));
      wr(32'h0040_0000 | 32'(r));
      run_ref(r * 240, r);
      chk(32'(active), 32'h1);
    end
    wr(32'h0060_0002);
    run_ref(400, 0);
    wr(32'h0040_0001);
    run_ref(400, 0);
    chk(32'(active), 32'h0);
    ce_in = 1'b0;
    wr(32'h0);
    ce_in = 1'b1;
    chk(rd_data, 32'h0040_0001);
    wrap_up;
  end
endmodule
bind rid_reference_input_divider rid_div_checker #(
  .INPUT_INDEX(INPUT_INDEX)) rid_div_checker_i (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .ce_in(ce_in), .ref_clk_in(ref_clk_in),
  .cfg_wr_en_in(cfg_wr_en_in), .cfg_wr_data_in(cfg_wr_data_in),
  .cfg_rd_data_out(cfg_rd_data_out), .select_key_out(select_key_out),
  .div_clk_out(div_clk_out), .div_active_out(div_active_out));
